// ### src/eeprom_byte_access_port.sv
// byte access port of the data nonvolatile array
//
// Operation
// - load index, set read_strobe, byte appears
// - power-down entry lets active write finish
// - after such write timing clock stays requested
// - reset does not abort write in progress
// - small variant: 9-bit index, 15:9 read zero
// - large variant: 11-bit index, 15:11 zero
// - index has no reset value
// - value register holds write or read byte
// - control bits 7:4 read zero
// - data-space address is io address plus 0x20
// - bit set/clear touch only addressed bit
// - arm clears after four cycles; gates strobe
// - write_strobe clears when write time elapses
// - write lasts 27072 oscillator cycles
// - ready interrupt level while write_strobe clear
`include "nv_access_defs.svh"
`timescale 1ns/1ps
module eeprom_byte_access_port #(
  parameter int INDEX_W         = 11,
  parameter int WRITE_RC_CYCLES = `NV_WRITE_RC_CYCLES
) (
  // clock and resets
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   power_on_n,
  // cpu io access
  input  wire nv_access_pkg::io_req_s req,
  output logic [7:0]                  io_rdata,
  // system state
  input  wire logic                   global_ie,
  input  wire logic                   sleep_pd,
  input  wire logic                   rc_tick,
  output logic                        irq_ready,
  output logic                        rc_clk_req
);
  localparam int DEPTH = 1 << INDEX_W;

  logic [7:0]             nv_mem [DEPTH];
  logic [INDEX_W-1:0]     nv_byte_index;
  logic [7:0]             nv_byte_value;
  logic                   ready_irq_enable;
  logic                   write_arm;
  logic [2:0]             arm_count;
  logic [14:0]            rc_count;
  logic                   rc_meta;
  logic                   rc_sync;
  logic                   rc_prev;
  nv_access_pkg::wr_state_e w_state;
  nv_access_pkg::wr_state_e next_w_state;

  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] val,
                                       input logic [7:0] mask);
    merge = (cur & ~mask) | (val & mask);
  endfunction

  // address decode, both io and data-space views
  wire [7:0] io_addr = req.is_data ? req.addr - `NV_DATA_SPACE : req.addr;
  wire in_range = req.is_data ?
    (req.addr >= `NV_DATA_SPACE && req.addr < `NV_IO_TOP + `NV_DATA_SPACE) :
    (req.addr < `NV_IO_TOP);
  wire sel_ctrl  = in_range && io_addr == `NV_CTRL_OFS;
  wire sel_value = in_range && io_addr == `NV_VALUE_OFS;
  wire sel_low   = in_range && io_addr == `NV_IDX_LOW_OFS;
  wire sel_high  = in_range && io_addr == `NV_IDX_HIGH_OFS;

  // single-bit ops only reach io addresses below 0x20
  wire bit_op = (req.bit_set || req.bit_clr) && !req.is_data &&
                req.addr < `NV_BIT_OP_TOP;
  wire [7:0] bit_mask = 8'h01 << req.bit_sel;
  wire [7:0] wr_mask = bit_op ? bit_mask : (req.wr ? 8'hFF : 8'h00);
  wire [7:0] wr_val = bit_op ? (req.bit_set ? 8'hFF : 8'h00) : req.wdata;
  wire any_wr = req.wr || bit_op;

  wire busy = w_state == nv_access_pkg::W_BUSY;
  wire [7:0] ctrl_rd = {4'h0, ready_irq_enable, write_arm, busy, 1'b0};
  wire [7:0] ctrl_new = merge(ctrl_rd, wr_val, wr_mask);
  wire ctrl_wr = any_wr && sel_ctrl && reset_n;
  wire arm_set = ctrl_wr && wr_mask[`NV_ARM_BIT] && ctrl_new[`NV_ARM_BIT];
  wire arm_clr = ctrl_wr && wr_mask[`NV_ARM_BIT] && !ctrl_new[`NV_ARM_BIT];
  wire start_write = ctrl_wr && wr_mask[`NV_STROBE_BIT] &&
                     ctrl_new[`NV_STROBE_BIT] && write_arm && !busy;
  wire start_read = ctrl_wr && wr_mask[`NV_READ_BIT] &&
                    ctrl_new[`NV_READ_BIT] && !busy;

  wire [15:0] idx16 = 16'(nv_byte_index);
  wire [7:0] new_low  = merge(idx16[7:0], wr_val, wr_mask);
  wire [7:0] new_high = merge(idx16[15:8], wr_val, wr_mask);
  wire idx_low_wr  = any_wr && sel_low && !busy;
  wire idx_high_wr = any_wr && sel_high && !busy;
  wire [7:0] mem_peek = nv_mem[nv_byte_index];

  wire rc_edge = rc_sync && !rc_prev;
  wire write_done = busy && rc_edge &&
                    rc_count == 15'(WRITE_RC_CYCLES - 1);

  wire [7:0] rd_mux = sel_low   ? idx16[7:0] :
                      sel_high  ? idx16[15:8] :
                      sel_value ? nv_byte_value :
                      sel_ctrl  ? ctrl_rd : 8'h00;

  // oscillator tick synchroniser
  always_ff @(posedge clk) begin
    rc_meta <= rc_tick;
    rc_sync <= rc_meta;
    rc_prev <= rc_sync;
  end

  // index has no reset; reserved high bits dropped by width
  always_ff @(posedge clk) begin
    if (idx_low_wr || idx_high_wr) begin
      nv_byte_index <= INDEX_W'({idx_high_wr ? new_high : idx16[15:8],
                                 idx_low_wr ? new_low : idx16[7:0]});
    end
  end

  // value register: read capture wins over a software write
  always_ff @(posedge clk) begin
    if (start_read) begin
      nv_byte_value <= mem_peek;
    end else if (any_wr && sel_value) begin
      nv_byte_value <= merge(nv_byte_value, wr_val, wr_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (write_done) begin
      nv_mem[nv_byte_index] <= nv_byte_value;
    end
  end

  // control bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ready_irq_enable <= 1'b0;
      write_arm        <= 1'b0;
      arm_count        <= 3'd0;
    end else begin
      if (ctrl_wr && wr_mask[`NV_RIE_BIT]) begin
        ready_irq_enable <= ctrl_new[`NV_RIE_BIT];
      end
      if (arm_set) begin
        write_arm <= 1'b1;
        arm_count <= 3'd0;
      end else if (arm_clr) begin
        write_arm <= 1'b0;
      end else if (write_arm) begin
        arm_count <= arm_count + 3'd1;
        if (arm_count == `NV_ARM_CYCLES - 3'd1) begin
          write_arm <= 1'b0;
        end
      end
    end
  end

  // write engine ignores reset_n so a running write completes
  always_comb begin
    next_w_state = w_state;
    unique case (w_state)
      nv_access_pkg::W_IDLE: begin
        if (start_write) next_w_state = nv_access_pkg::W_BUSY;
      end
      nv_access_pkg::W_BUSY: begin
        if (write_done) begin
          next_w_state = sleep_pd ? nv_access_pkg::W_HOLD :
                                    nv_access_pkg::W_IDLE;
        end
      end
      nv_access_pkg::W_HOLD: begin
        if (start_write) next_w_state = nv_access_pkg::W_BUSY;
        else if (!sleep_pd) next_w_state = nv_access_pkg::W_IDLE;
      end
      default: next_w_state = nv_access_pkg::W_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!power_on_n) begin
      w_state    <= nv_access_pkg::W_IDLE;
      rc_count   <= 15'd0;
      rc_clk_req <= 1'b0;
    end else begin
      w_state    <= next_w_state;
      rc_clk_req <= next_w_state != nv_access_pkg::W_IDLE;
      if (start_write) begin
        rc_count <= 15'd0;
      end else if (busy && rc_edge) begin
        rc_count <= rc_count + 15'd1;
      end
    end
  end

  // io read data and ready interrupt level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      io_rdata  <= 8'h00;
      irq_ready <= 1'b0;
    end else begin
      if (req.rd) io_rdata <= rd_mux;
      irq_ready <= ready_irq_enable && global_ie &&
                   next_w_state != nv_access_pkg::W_BUSY;
    end
  end

  // port checks; either reset pauses all but reset_keeps_a, which only power_on_n pauses
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !power_on_n);

  sequence arm_window;
    $rose(write_arm) ##0 (!arm_set && !arm_clr)[*4];
  endsequence

  sequence done_in_sleep;
    write_done && sleep_pd;
  endsequence

  arm_timeout_a: assert property (
    arm_window |=> !write_arm)
    else $error("write arm not cleared after four cycles");

  strobe_armed_a: assert property (
    $rose(busy) |-> $past(write_arm))
    else $error("write started without arm");

  write_length_a: assert property (
    $fell(busy) |-> $past(rc_edge) &&
      $past(rc_count) == 15'(WRITE_RC_CYCLES - 1))
    else $error("write ended at wrong oscillator count");

  read_capture_a: assert property (
    start_read |=> nv_byte_value == $past(mem_peek) && !busy)
    else $error("read byte not captured");

  ctrl_reserved_a: assert property (
    req.rd && sel_ctrl |=> io_rdata[7:4] == 4'h0)
    else $error("control reserved bits not zero");

  index_reserved_a: assert property (
    req.rd && sel_high |=> (io_rdata >> (INDEX_W - 8)) == 8'h00)
    else $error("index reserved bits not zero");

  irq_level_a: assert property (
    (ready_irq_enable && global_ie && !busy)[*2] |-> irq_ready)
    else $error("ready interrupt missing");

  sleep_hold_a: assert property (
    done_in_sleep |=> w_state == nv_access_pkg::W_HOLD && rc_clk_req)
    else $error("timing clock dropped after sleep write");

  bit_only_a: assert property (
    bit_op && sel_ctrl && req.bit_sel == 3'(`NV_RIE_BIT) && !write_done
      |=> ready_irq_enable == $past(req.bit_set) && busy == $past(busy))
    else $error("bit op disturbed other bits");

  io_map_a: assert property (
    req.rd && req.is_data && !busy &&
      req.addr == `NV_IDX_LOW_OFS + `NV_DATA_SPACE
      |=> io_rdata == $past(idx16[7:0]))
    else $error("data-space alias mismatch");

  reset_keeps_a: assert property (
    @(posedge clk) disable iff (!power_on_n)
    busy && !reset_n && !write_done |=> busy)
    else $error("reset aborted write");

  write_begin_a: assert property (
    start_write |=> busy && rc_clk_req && rc_count == 15'd0)
    else $error("armed strobe did not start a write");

  arm_hold_a: assert property (
    arm_set |=> write_arm)
    else $error("write arm not set by software");

  strobe_refused_a: assert property (
    ctrl_wr && wr_mask[`NV_STROBE_BIT] && ctrl_new[`NV_STROBE_BIT] &&
      !write_arm && !busy |=> !busy)
    else $error("strobe honoured without arm");

  write_commit_a: assert property (
    write_done |=> nv_mem[$past(nv_byte_index)] == $past(nv_byte_value))
    else $error("array byte not written at write end");

  strobe_clear_a: assert property (
    write_done |=> !busy)
    else $error("write strobe still set after write time");

  sleep_write_a: assert property (
    busy && sleep_pd && !write_done |=> busy)
    else $error("write stopped by power-down entry");

  hold_release_a: assert property (
    w_state == nv_access_pkg::W_HOLD && !sleep_pd && !start_write
      |=> !rc_clk_req)
    else $error("timing clock kept after sleep ended");
endmodule

// ### src/nv_access_defs.svh
// offsets, field positions and counts of the byte access port
`ifndef NV_ACCESS_DEFS_SVH
`define NV_ACCESS_DEFS_SVH
`define NV_CTRL_OFS      8'h1F
`define NV_VALUE_OFS     8'h20
`define NV_IDX_LOW_OFS   8'h21
`define NV_IDX_HIGH_OFS  8'h22
`define NV_DATA_SPACE    8'h20
`define NV_IO_TOP        8'h40
`define NV_BIT_OP_TOP    8'h20
`define NV_READ_BIT      0
`define NV_STROBE_BIT    1
`define NV_ARM_BIT       2
`define NV_RIE_BIT       3
`define NV_ARM_CYCLES    3'd4
`define NV_WRITE_RC_CYCLES 27072
`endif

// ### src/nv_access_pkg.sv
// types of the byte access port
package nv_access_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       is_data;
    logic       wr;
    logic       rd;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } io_req_s;
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_BUSY = 3'b010,
    W_HOLD = 3'b100
  } wr_state_e;
endpackage

// ### tb/cpu_model.sv
// cpu side model issuing io loads, stores and bit operations
`timescale 1ns/1ps
module cpu_model (
  // bus side
  input  wire logic              clk,
  output nv_access_pkg::io_req_s req,
  input  wire logic [7:0]        io_rdata
);
  initial req = '0;
  // a is {is_data, addr}; op is {wr, rd, bit_set, bit_clr}
  task automatic acc(input logic [8:0] a, input logic [3:0] op,
                     input logic [2:0] sel, input logic [7:0] d);
    @(posedge clk);
    req <= '{a[7:0], a[8], op[3], op[2], op[1], op[0], sel, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    acc(a, 4'h8, 3'h0, d);
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    acc(a, 4'h4, 3'h0, 8'h00);
    @(negedge clk);
    d = io_rdata;
  endtask
  // index and value first, then arm, then strobe as its own access
  task automatic nv_write(input logic [10:0] idx, input logic [7:0] v);
    wr(9'h021, idx[7:0]);
    wr(9'h022, {5'h00, idx[10:8]});
    wr(9'h020, v);
    wr(9'h01F, 8'h04);
    wr(9'h01F, 8'h06);
  endtask
  // same write, arm and strobe set by single-bit operations
  task automatic nv_write_bits(input logic [10:0] idx, input logic [7:0] v);
    wr(9'h021, idx[7:0]);
    wr(9'h022, {5'h00, idx[10:8]});
    wr(9'h020, v);
    acc(9'h01F, 4'h2, 3'h2, 8'h00);
    acc(9'h01F, 4'h2, 3'h1, 8'h00);
  endtask
endmodule

// ### tb/eeprom_byte_access_port_tb.sv
// self-checking bench of the byte access port
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module eeprom_byte_access_port_tb;
  logic                   clk = 0;
  logic                   reset_n = 0;
  logic                   power_on_n = 0;
  logic                   global_ie = 0;
  logic                   sleep_pd = 0;
  logic                   rc_tick = 0;
  logic                   irq_ready;
  logic                   rc_clk_req;
  logic [7:0]             io_rdata;
  nv_access_pkg::io_req_s req;
  logic                   rd_d = 0;
  logic [8:0]             exp_q[$];
  logic [8:0]             e;
  logic [31:0]            lfsr = 32'h435A07AB;
  logic [10:0]            idx;
  logic [7:0]             v;
  int                     error_cnt = 0;
  int                     cmp_count = 0;
  eeprom_byte_access_port #(.INDEX_W(11), .WRITE_RC_CYCLES(8))
    u_eeprom_byte_access_port (
    .clk(clk), .reset_n(reset_n), .power_on_n(power_on_n), .req(req),
    .io_rdata(io_rdata), .global_ie(global_ie), .sleep_pd(sleep_pd),
    .rc_tick(rc_tick), .irq_ready(irq_ready), .rc_clk_req(rc_clk_req));
  cpu_model u_cpu_model (.clk(clk), .req(req), .io_rdata(io_rdata));
  initial forever #12.5 clk = ~clk;
  // oscillator stand-in: a rising edge every six clocks
  initial forever begin
    repeat (3) @(posedge clk);
    rc_tick <= ~rc_tick;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // result watcher: each read answer is matched to the oldest note
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8]) `CHK(io_rdata, e[7:0])
    end
  end
  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rdx(input logic [8:0] a, input logic c,
                     input logic [7:0] x, output logic [7:0] d);
    exp_q.push_back({c, x});
    u_cpu_model.rd(a, d);
  endtask
  task automatic chk_rd(input logic [8:0] a, input logic [7:0] x);
    logic [7:0] d;
    rdx(a, 1'b1, x, d);
  endtask
  task automatic poll;
    logic [7:0] d;
    int         n;
    n = 0;
    rdx(9'h01F, 1'b0, 8'h00, d);
    `CHK(d[1], 1'b1)
    while (d[1] && n < 200) begin
      rdx(9'h01F, 1'b0, 8'h00, d);
      n++;
    end
    if (d[1]) begin
      error_cnt++;
      $display("BAD %0t write never completed", $time);
      give_verdict;
    end
  endtask
  task automatic read_back(input logic [10:0] i, input logic [7:0] x);
    u_cpu_model.wr(9'h021, i[7:0]);
    u_cpu_model.wr(9'h022, {5'h00, i[10:8]});
    chk_rd(9'h022, {5'h00, i[10:8]});
    chk_rd(9'h141, i[7:0]);
    u_cpu_model.wr(9'h020, ~x);
    u_cpu_model.wr(9'h01F, 8'h01);
    chk_rd(9'h140, x);
  endtask
  task automatic rnd;
    lfsr = lfsr_next(lfsr);
    idx = lfsr[10:0];
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0];
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    power_on_n <= 1'b1;
    chk_rd(9'h01F, 8'h00);
    u_cpu_model.wr(9'h022, 8'hFF);
    chk_rd(9'h142, 8'h07);
    $display("test register map done");
    repeat (3) begin
      rnd;
      u_cpu_model.nv_write(idx, v);
      poll;
      read_back(idx, v);
    end
    $display("test write and read done");
    u_cpu_model.wr(9'h01F, 8'h04);
    repeat (6) @(posedge clk);
    u_cpu_model.wr(9'h01F, 8'h02);
    chk_rd(9'h01F, 8'h00);
    $display("test arm timeout done");
    rnd;
    u_cpu_model.nv_write(idx, v);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    poll;
    read_back(idx, v);
    $display("test reset in write done");
    rnd;
    u_cpu_model.nv_write(idx, v);
    sleep_pd <= 1'b1;
    poll;
    repeat (2) @(posedge clk);
    `CHK(rc_clk_req, 1'b1)
    sleep_pd <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(rc_clk_req, 1'b0)
    read_back(idx, v);
    $display("test sleep in write done");
    @(posedge clk);
    global_ie <= 1'b1;
    u_cpu_model.acc(9'h01F, 4'h2, 3'h3, 8'h00);
    chk_rd(9'h01F, 8'h08);
    `CHK(irq_ready, 1'b1)
    rnd;
    u_cpu_model.nv_write_bits(idx, v);
    repeat (2) @(posedge clk);
    `CHK(irq_ready, 1'b0)
    poll;
    `CHK(irq_ready, 1'b1)
    u_cpu_model.acc(9'h01F, 4'h1, 3'h3, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(irq_ready, 1'b0)
    read_back(idx, v);
    $display("test ready interrupt done");
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule
